// file: rtl/tblm_pkg.sv
// Constants and carrier types for the 10BASE-T link monitor
package tblm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_NS = 10;
	localparam int NS_PER_MS = 1_000_000;
	localparam int BIT_NS = 100;
	localparam int SQE_BT = 10;
	localparam int SQE_CYC = (SQE_BT * BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int LP_NS = 100;
	localparam int LP_CYC = (LP_NS + CLK_NS - 1) / CLK_NS;
	localparam int NLP_MS = 16;
	localparam int NLP_CYC = NLP_MS * (NS_PER_MS / CLK_NS);
	localparam int RX_TMO_MS = 96;
	localparam int RX_TMO_CYC = RX_TMO_MS * (NS_PER_MS / CLK_NS);
	localparam int JABBER_MS = 20;
	localparam int JABBER_CYC = JABBER_MS * (NS_PER_MS / CLK_NS);
	localparam int UNJAB_MS = 500;
	localparam int UNJAB_CYC = UNJAB_MS * (NS_PER_MS / CLK_NS);

	////////////////////////////////////////////////////////////////////////
	// Polarity detection counts
	localparam int POL_LP_CNT = 8;
	localparam int POL_EOF_CNT = 4;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] REG_STATUS = 5'h01;
	localparam logic [4:0] REG_PAGE = 5'h06;
	localparam logic [4:0] REG_CFG = 5'h10;
	localparam logic [4:0] REG_STAT2 = 5'h11;
	localparam int ST_LINK_BIT = 2;
	localparam int PG_RX_BIT = 1;
	localparam int PG_BASE_BIT = 5;
	localparam int CFG_LTD_BIT = 14;
	localparam int CFG_UNJ_DIS_BIT = 10;
	localparam int CFG_SQE_BIT = 9;
	localparam int CFG_ALTNP_BIT = 1;
	localparam int CFG_AN_EN_BIT = 0;
	localparam logic [15:0] CFG_RESET = 16'h0001;
	localparam int S2_SPEED_BIT = 14;
	localparam int S2_LINK_BIT = 10;
	localparam int S2_DUPLEX_BIT = 9;
	localparam int S2_ANDONE_BIT = 7;
	localparam int S2_POL_BIT = 5;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic activity;
		logic eof_inv;
		logic eof;
		logic pulse_inv;
		logic pulse;
	} tblm_line_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tblm_reg_req_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic an_complete;
		logic an_start;
		logic page_rx;
		logic base_page;
	} tblm_an_t;

	typedef enum logic [1:0] {
		TBLM_TX_IDLE = 2'b00,
		TBLM_TX_ACTIVE = 2'b01,
		TBLM_TX_JABBER = 2'b11
	} tblm_jab_t;

endpackage : tblm_pkg

// file: rtl/tblm_top.sv
// 10BASE-T receive, link, heartbeat, jabber and status monitor

// How it works
// - One to four dribble bits: final nibble still sent, padded with ones.
// - Five to seven dribble bits: incomplete second nibble is dropped.
// - At 10 Mb/s link pulses go out continuously.
// - Link test on: transmit enabled after pulses, kept while traffic.
// - Config bit 16.14 set: link test off, transmit allowed except in jabber.
// - Pulses stop with link test on: link fails, renegotiate if enabled.
// - Heartbeat off at reset; bit 16.9 gives collision after each packet.
// - Overlong transmission disables transmit and loopback paths.
// - Jabber exits after unjabber time unless bit 16.10 is set.
// - Eight inverted pulses or four inverted end markers flip polarity.
// - No pulses or data for receive time-out: polarity back to normal.
// - Inverted polarity at 10 Mb/s shows in status bit 17.5.
// - Status bit 17.7 shows negotiation complete.
// - Bits 1.2 and 17.10 show link established.
// - Bit 17.14 shows speed, bit 17.9 shows duplex.
// - Page-received bit 6.1 sticks until read.
// - Alternate next-page mode clears 6.1 when negotiation restarts.
// - Bit 6.5 marks the received page as base page.
// - Reading register 6 clears bits 6.1 and 6.5.
// - Link failure shows in link bits and a failure event output.
module tblm_top #(
	parameter int unsigned NLP_CYC = tblm_pkg::NLP_CYC, // Link pulse period
	parameter int unsigned RX_TMO_CYC = tblm_pkg::RX_TMO_CYC, // Rx time-out
	parameter int unsigned JABBER_CYC = tblm_pkg::JABBER_CYC, // Jabber limit
	parameter int unsigned UNJAB_CYC = tblm_pkg::UNJAB_CYC // Unjabber time
) (
	input wire logic clock_in, // 100 MHz clock
	input wire logic rst_in, // Async reset, high
	input wire tblm_pkg::tblm_reg_req_t reg_req_in, // Register access
	output logic [15:0] rd_data_out, // Read data, cycle after read
	input wire tblm_pkg::tblm_line_t line_in, // Line events, async
	input wire logic rx_bit_in, // Decoded receive bit
	input wire logic rx_bit_valid_in, // Receive bit strobe
	input wire logic rx_frame_in, // Receive frame in progress
	input wire logic tx_en_in, // MAC transmit enable
	input wire tblm_pkg::tblm_an_t an_in, // Negotiation status
	output logic [3:0] rxd_out, // Receive nibble to MII
	output logic rx_nib_valid_out, // Nibble strobe
	output logic tx_link_pulse_out, // Link pulse to line driver
	output logic tx_enable_out, // Data transmission allowed
	output logic loopback_enable_out, // Loopback path allowed
	output logic col_out, // Collision / heartbeat
	output logic rx_invert_out, // Receive pair correction
	output logic an_restart_out, // Renegotiate pulse
	output logic link_fail_out // Link failure event pulse
);
	import tblm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pad a partial nibble, received bits sit at the top
	function automatic logic [3:0] pad_nib(input logic [3:0] sh,
		input logic [1:0] k);
		logic [3:0] r;
		r = sh;
		case (k)
			2'h1: r = {3'h7, sh[3]};
			2'h2: r = {2'h3, sh[3:2]};
			2'h3: r = {1'h1, sh[3:1]};
			default: r = sh;
		endcase
		return r;
	endfunction : pad_nib

	////////////////////////////////////////////////////////////////////////
	// Line input synchroniser and edge detection
	tblm_line_t line_s1_q, line_s2_q, line_s3_q;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			line_s1_q <= '0;
			line_s2_q <= '0;
			line_s3_q <= '0;
		end else begin
			line_s1_q <= line_in;
			line_s2_q <= line_s1_q;
			line_s3_q <= line_s2_q;
		end
	end

	logic pulse_evt, eof_evt, any_rx;
	assign pulse_evt = line_s2_q.pulse & ~line_s3_q.pulse;
	assign eof_evt = line_s2_q.eof & ~line_s3_q.eof;
	assign any_rx = pulse_evt | eof_evt | line_s2_q.activity |
		rx_bit_valid_in;

	////////////////////////////////////////////////////////////////////////
	// Configuration register
	logic [15:0] cfg_q;
	logic ltd, unj_dis, sqe_en, altnp, an_en;
	assign ltd = cfg_q[CFG_LTD_BIT];
	assign unj_dis = cfg_q[CFG_UNJ_DIS_BIT];
	assign sqe_en = cfg_q[CFG_SQE_BIT];
	assign altnp = cfg_q[CFG_ALTNP_BIT];
	assign an_en = cfg_q[CFG_AN_EN_BIT];

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= CFG_RESET;
		end else if (reg_req_in.wr && reg_req_in.addr == REG_CFG) begin
			cfg_q <= reg_req_in.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive inactivity timer, shared by link test and polarity
	logic [31:0] tmo_cnt_q;
	logic tmo_hit;
	assign tmo_hit = ~any_rx && tmo_cnt_q == 32'(RX_TMO_CYC - 1);

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tmo_cnt_q <= '0;
		end else if (any_rx) begin
			tmo_cnt_q <= '0;
		end else if (tmo_cnt_q != 32'(RX_TMO_CYC)) begin
			tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link integrity
	logic link_ok_q, link_fail_q, an_restart_q;
	logic link_drop;
	assign link_drop = link_ok_q & tmo_hit & ~ltd;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			link_ok_q <= 1'b0;
			link_fail_q <= 1'b0;
			an_restart_q <= 1'b0;
		end else begin
			if (pulse_evt) begin
				link_ok_q <= 1'b1;
			end else if (link_drop) begin
				link_ok_q <= 1'b0;
			end
			link_fail_q <= link_drop;
			an_restart_q <= link_drop & an_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outgoing link pulses, independent of the link test
	logic [31:0] nlp_cnt_q;
	logic [7:0] lp_w_q;
	logic tx_lp_q;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			nlp_cnt_q <= '0;
			lp_w_q <= '0;
			tx_lp_q <= 1'b0;
		end else if (an_in.speed_100) begin
			nlp_cnt_q <= '0;
			lp_w_q <= '0;
			tx_lp_q <= 1'b0;
		end else if (nlp_cnt_q == 32'(NLP_CYC - 1)) begin
			nlp_cnt_q <= '0;
			lp_w_q <= 8'(LP_CYC - 1);
			tx_lp_q <= 1'b1;
		end else begin
			nlp_cnt_q <= nlp_cnt_q + 32'h0000_0001;
			if (lp_w_q != '0) begin
				lp_w_q <= lp_w_q - 8'h01;
			end else begin
				tx_lp_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Jabber watchdog; unjabber counts transmit-idle time
	tblm_jab_t jab_q;
	logic [31:0] jab_cnt_q;
	logic tx_en_q;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			jab_q <= TBLM_TX_IDLE;
			jab_cnt_q <= '0;
		end else begin
			case (jab_q)
				TBLM_TX_IDLE: begin
					jab_cnt_q <= '0;
					if (tx_en_in) begin
						jab_q <= TBLM_TX_ACTIVE;
					end
				end
				TBLM_TX_ACTIVE: begin
					if (!tx_en_in) begin
						jab_q <= TBLM_TX_IDLE;
					end else if (jab_cnt_q == 32'(JABBER_CYC - 1)) begin
						jab_q <= TBLM_TX_JABBER;
						jab_cnt_q <= '0;
					end else begin
						jab_cnt_q <= jab_cnt_q + 32'h0000_0001;
					end
				end
				TBLM_TX_JABBER: begin
					if (tx_en_in) begin
						jab_cnt_q <= '0;
					end else if (jab_cnt_q == 32'(UNJAB_CYC - 1)) begin
						// Held here while auto exit is disabled
						if (!unj_dis) begin
							jab_q <= TBLM_TX_IDLE;
						end
					end else begin
						jab_cnt_q <= jab_cnt_q + 32'h0000_0001;
					end
				end
				default: begin
					jab_q <= TBLM_TX_IDLE;
					jab_cnt_q <= '0;
				end
			endcase
		end
	end

	logic jabber;
	assign jabber = jab_q == TBLM_TX_JABBER;

	logic tx_ok_q, lb_ok_q;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tx_ok_q <= 1'b0;
			lb_ok_q <= 1'b0;
		end else begin
			tx_ok_q <= (ltd | link_ok_q) & ~jabber;
			lb_ok_q <= ~jabber;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Heartbeat after each transmitted packet
	logic [7:0] sqe_cnt_q;
	logic col_q;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tx_en_q <= 1'b0;
			sqe_cnt_q <= '0;
			col_q <= 1'b0;
		end else begin
			tx_en_q <= tx_en_in;
			if (tx_en_q && !tx_en_in && sqe_en && !jabber) begin
				sqe_cnt_q <= 8'(SQE_CYC);
				col_q <= 1'b1;
			end else if (sqe_cnt_q != '0) begin
				sqe_cnt_q <= sqe_cnt_q - 8'h01;
				col_q <= sqe_cnt_q != 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive polarity detection
	logic [3:0] lp_inv_q, eof_inv_q;
	logic pol_q;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			lp_inv_q <= '0;
			eof_inv_q <= '0;
			pol_q <= 1'b0;
		end else if (tmo_hit) begin
			lp_inv_q <= '0;
			eof_inv_q <= '0;
			pol_q <= 1'b0;
		end else begin
			if (pulse_evt) begin
				if (!line_s2_q.pulse_inv) begin
					lp_inv_q <= '0;
				end else if (lp_inv_q == 4'(POL_LP_CNT - 1)) begin
					lp_inv_q <= '0;
					pol_q <= 1'b1;
				end else begin
					lp_inv_q <= lp_inv_q + 4'h1;
				end
			end
			if (eof_evt) begin
				if (!line_s2_q.eof_inv) begin
					eof_inv_q <= '0;
				end else if (eof_inv_q == 4'(POL_EOF_CNT - 1)) begin
					eof_inv_q <= '0;
					pol_q <= 1'b1;
				end else begin
					eof_inv_q <= eof_inv_q + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Nibble assembly with dribble handling, bits arrive LSB first
	logic [3:0] sh_q, rxd_q;
	logic [2:0] bit_cnt_q;
	logic frame_q, nib_v_q;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			sh_q <= '0;
			bit_cnt_q <= '0;
			frame_q <= 1'b0;
			rxd_q <= '0;
			nib_v_q <= 1'b0;
		end else begin
			frame_q <= rx_frame_in;
			nib_v_q <= 1'b0;
			if (rx_bit_valid_in) begin
				sh_q <= {rx_bit_in, sh_q[3:1]};
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (bit_cnt_q[1:0] == 2'h3) begin
					rxd_q <= {rx_bit_in, sh_q[3:1]};
					nib_v_q <= 1'b1;
				end
			end else if (frame_q && !rx_frame_in) begin
				bit_cnt_q <= '0;
				// Residue 1..3 in the low nibble only; upper one dropped
				if (!bit_cnt_q[2] && bit_cnt_q[1:0] != 2'h0) begin
					rxd_q <= pad_nib(sh_q, bit_cnt_q[1:0]);
					nib_v_q <= 1'b1;
				end
			end else if (!rx_frame_in) begin
				bit_cnt_q <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Page flags, cleared by reading their register; a set wins
	logic pg_rx_q, pg_base_q, pg_rd;
	assign pg_rd = reg_req_in.rd && reg_req_in.addr == REG_PAGE;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pg_rx_q <= 1'b0;
			pg_base_q <= 1'b0;
		end else begin
			if (an_in.page_rx) begin
				pg_rx_q <= 1'b1;
			end else if (pg_rd || (altnp && an_in.an_start)) begin
				pg_rx_q <= 1'b0;
			end
			if (an_in.page_rx && an_in.base_page) begin
				pg_base_q <= 1'b1;
			end else if (pg_rd) begin
				pg_base_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read port
	logic [15:0] rd_q, rd_d;
	always_comb begin
		rd_d = '0;
		case (reg_req_in.addr)
			REG_STATUS: rd_d[ST_LINK_BIT] = link_ok_q;
			REG_PAGE: begin
				rd_d[PG_RX_BIT] = pg_rx_q;
				rd_d[PG_BASE_BIT] = pg_base_q;
			end
			REG_CFG: rd_d = cfg_q;
			REG_STAT2: begin
				rd_d[S2_SPEED_BIT] = an_in.speed_100;
				rd_d[S2_LINK_BIT] = link_ok_q;
				rd_d[S2_DUPLEX_BIT] = an_in.full_duplex;
				rd_d[S2_ANDONE_BIT] = an_in.an_complete;
				rd_d[S2_POL_BIT] = pol_q & ~an_in.speed_100;
			end
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rd_q <= '0;
		end else if (reg_req_in.rd) begin
			rd_q <= rd_d;
		end else begin
			rd_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all registered
	assign rd_data_out = rd_q;
	assign rxd_out = rxd_q;
	assign rx_nib_valid_out = nib_v_q;
	assign tx_link_pulse_out = tx_lp_q;
	assign tx_enable_out = tx_ok_q;
	assign loopback_enable_out = lb_ok_q;
	assign col_out = col_q;
	assign rx_invert_out = pol_q;
	assign an_restart_out = an_restart_q;
	assign link_fail_out = link_fail_q;

endmodule : tblm_top

// file: verif/tblm_sva.sv
// Port-level assertions for the 10BASE-T link monitor
module tblm_sva #(
	parameter int unsigned NLP_CYC = 200, // Link pulse period
	parameter int unsigned JABBER_CYC = 300, // Jabber limit
	parameter int unsigned UNJAB_CYC = 400 // Unjabber time
) (
	input wire logic clock_in, // Clock
	input wire logic rst_in, // Reset
	input wire tblm_pkg::tblm_reg_req_t reg_req_in, // Register access
	input wire tblm_pkg::tblm_an_t an_in, // Negotiation status
	input wire logic tx_en_in, // MAC transmit
	input wire logic tx_link_pulse_out, // Link pulse
	input wire logic tx_enable_out, // Tx allowed
	input wire logic loopback_enable_out, // Loopback allowed
	input wire logic col_out, // Heartbeat
	input wire logic an_restart_out, // Renegotiate
	input wire logic link_fail_out // Link failure
);
	timeunit 1ns;
	timeprecision 1ps;
	import tblm_pkg::*;
	logic [15:0] cfg_q;
	int unsigned gap_q;
	int unsigned col_q;
	int unsigned on_q;
	int unsigned off_q;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////////////
	// Config shadow; bus writes are the only way it changes
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= CFG_RESET;
		end else if (reg_req_in.wr && reg_req_in.addr == REG_CFG) begin
			cfg_q <= reg_req_in.wdata;
		end
	end
	// Run lengths
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gap_q <= 0;
			col_q <= 0;
			on_q <= 0;
			off_q <= 0;
		end else begin
			gap_q <= (tx_link_pulse_out || an_in.speed_100) ? 0 : gap_q + 1;
			col_q <= col_out ? col_q + 1 : 0;
			on_q <= tx_en_in ? on_q + 1 : 0;
			off_q <= tx_en_in ? 0 : off_q + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	AST_LINK_PULSE: assert property (gap_q <= NLP_CYC + 8)
		else $error("link pulse gap");
	AST_LTD_TX: assert property ($past(cfg_q[CFG_LTD_BIT])
		&& cfg_q[CFG_LTD_BIT] && loopback_enable_out |-> tx_enable_out)
		else $error("override ignored");
	AST_LINK_FAIL: assert property (link_fail_out |->
		!cfg_q[CFG_LTD_BIT] ##1 !tx_enable_out) else $error("link fail");
	AST_AN_RESTART: assert property (link_fail_out
		&& cfg_q[CFG_AN_EN_BIT] |-> ##[0:1] an_restart_out)
		else $error("no restart");
	AST_HB_START: assert property ($fell(tx_en_in)
		&& cfg_q[CFG_SQE_BIT] && loopback_enable_out |-> ##1 $rose(col_out))
		else $error("no heartbeat");
	AST_HB_LEN: assert property ($fell(col_out) |-> col_q >= 50
		&& col_q <= 150) else $error("heartbeat length");
	AST_JAB_OFF: assert property (on_q > JABBER_CYC + 2 |->
		!tx_enable_out && !loopback_enable_out) else $error("no jabber");
	AST_UNJAB: assert property (off_q > UNJAB_CYC + 3
		&& !cfg_q[CFG_UNJ_DIS_BIT] |-> ##[0:3] loopback_enable_out)
		else $error("no unjabber");
endmodule : tblm_sva

// file: verif/tblm_remote.sv
// Remote 10BASE-T station: line events and decoded receive bits
module tblm_remote (
	input wire logic clock_in, // Bench clock
	output tblm_pkg::tblm_line_t line_out, // Line events
	output logic bit_out, // Decoded bit
	output logic bit_vld_out, // Bit strobe
	output logic frame_out // Frame in progress
);
	timeunit 1ns;
	timeprecision 1ps;
	import tblm_pkg::*;
	initial begin
		line_out = '0;
		{bit_out, bit_vld_out, frame_out} = 3'b000;
	end
	////////////////////////////////////////////////////////////////////////
	// Low gap lets the synchroniser see separate events
	task automatic send(input logic inv, input logic eof);
		@(posedge clock_in);
		line_out <= '{1'b0, inv, eof, inv, !eof};
		repeat (3) @(posedge clock_in);
		line_out <= '0;
		repeat (3) @(posedge clock_in);
		@(negedge clock_in);
	endtask : send
	// Idle bit line flips so a stale value is never read as data
	task automatic frame(input int n, input logic [15:0] d);
		@(posedge clock_in);
		frame_out <= 1'b1;
		line_out.activity <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clock_in);
			bit_out <= d[i];
			bit_vld_out <= 1'b1;
			@(posedge clock_in);
			bit_out <= !d[i];
			bit_vld_out <= 1'b0;
		end
		@(posedge clock_in);
		frame_out <= 1'b0;
		line_out.activity <= 1'b0;
	endtask : frame
endmodule : tblm_remote

// file: verif/tb_top.sv
// Self-checking bench for the 10BASE-T link monitor
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tblm_pkg::*;
	localparam int P_TMO = 500;
	localparam int P_JAB = 300;
	localparam int P_UNJ = 400;
	logic clock_in, rst_in, tx_en_in, rx_bit_in, rx_bit_valid_in, rx_frame_in;
	tblm_reg_req_t reg_req_in;
	tblm_line_t line_in;
	tblm_an_t an_in;
	logic [15:0] rd_data_out;
	logic [3:0] rxd_out;
	logic rx_nib_valid_out, tx_link_pulse_out, tx_enable_out, col_out;
	logic loopback_enable_out, rx_invert_out, an_restart_out, link_fail_out;
	int num_errors;
	int cmp_count;
	logic fail_seen, restart_seen, lp_seen;
	logic [3:0] nibs[$];
	tblm_top #(.NLP_CYC(200), .RX_TMO_CYC(P_TMO), .JABBER_CYC(P_JAB),
		.UNJAB_CYC(P_UNJ)) u_dut (.clock_in, .rst_in, .reg_req_in,
		.rd_data_out, .line_in, .rx_bit_in, .rx_bit_valid_in, .rx_frame_in,
		.tx_en_in, .an_in, .rxd_out, .rx_nib_valid_out, .tx_link_pulse_out,
		.tx_enable_out, .loopback_enable_out, .col_out, .rx_invert_out,
		.an_restart_out, .link_fail_out);
	tblm_remote u_rem (.clock_in, .line_out(line_in), .bit_out(rx_bit_in),
		.bit_vld_out(rx_bit_valid_in), .frame_out(rx_frame_in));
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		if (rx_nib_valid_out === 1'b1) nibs.push_back(rxd_out);
		if (link_fail_out === 1'b1) fail_seen = 1'b1;
		if (an_restart_out === 1'b1) restart_seen = 1'b1;
		if (tx_link_pulse_out === 1'b1) lp_seen = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Sample off the edge so register updates have landed
	task automatic look(input int n);
		repeat (n) @(posedge clock_in);
		@(negedge clock_in);
	endtask : look
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock_in);
		reg_req_in <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_in);
		reg_req_in <= '0;
	endtask : wr_reg
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] m,
		input logic [15:0] e);
		@(posedge clock_in);
		reg_req_in <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clock_in);
		reg_req_in <= '0;
		@(negedge clock_in);
		chk(rd_data_out & m, e);
	endtask : rd_chk
	task automatic an_evt(input logic pg, input logic st, input logic bp);
		@(posedge clock_in);
		an_in.page_rx <= pg;
		an_in.an_start <= st;
		an_in.base_page <= bp;
		@(posedge clock_in);
		an_in.page_rx <= 1'b0;
		an_in.an_start <= 1'b0;
	endtask : an_evt
	////////////////////////////////////////////////////////////////////////
	task automatic t_ltd;
		look(1);
		chk(16'({tx_enable_out, col_out}), 16'h0000);
		rd_chk(REG_CFG, 16'hFFFF, CFG_RESET);
		rd_chk(5'h1F, 16'hFFFF, 16'h0000);
		wr_reg(REG_CFG, 16'h4001);
		look(3);
		chk(16'(tx_enable_out), 16'h0001);
		look(P_TMO + 20);
		chk(16'({lp_seen, fail_seen, tx_enable_out}), 16'h0005);
		wr_reg(REG_CFG, CFG_RESET);
		look(3);
		chk(16'(tx_enable_out), 16'h0000);
		$display("override done");
	endtask : t_ltd
	task automatic t_link;
		u_rem.send(1'b0, 1'b0);
		look(6);
		chk(16'(tx_enable_out), 16'h0001);
		rd_chk(REG_STATUS, 16'h0004, 16'h0004);
		rd_chk(REG_STAT2, 16'h0400, 16'h0400);
		repeat (3) begin
			u_rem.send(1'b0, 1'b0);
			look(P_TMO - 100);
		end
		chk(16'({restart_seen, fail_seen, tx_enable_out}), 16'h0001);
		look(P_TMO + 20);
		chk(16'({restart_seen, fail_seen, tx_enable_out}), 16'h0006);
		rd_chk(REG_STATUS, 16'h0004, 16'h0000);
		rd_chk(REG_STAT2, 16'h0400, 16'h0000);
		$display("link done");
	endtask : t_link
	task automatic t_pol;
		for (int i = 0; i < 8; i++) begin
			chk(16'(rx_invert_out), 16'h0000);
			u_rem.send(1'b1, 1'b0);
		end
		look(4);
		chk(16'(rx_invert_out), 16'h0001);
		rd_chk(REG_STAT2, 16'h0020, 16'h0020);
		look(P_TMO + 20);
		chk(16'(rx_invert_out), 16'h0000);
		for (int i = 0; i < 7; i++) u_rem.send(i != 3, 1'b1);
		chk(16'(rx_invert_out), 16'h0000);
		u_rem.send(1'b1, 1'b1);
		look(4);
		chk(16'(rx_invert_out), 16'h0001);
		$display("polarity done");
	endtask : t_pol
	task automatic t_drib;
		nibs.delete();
		u_rem.frame(9, 16'h00A5);
		look(4);
		chk(16'(nibs.size()), 16'h0003);
		chk({4'h0, nibs[2], nibs[1], nibs[0]}, 16'h0EA5);
		nibs.delete();
		u_rem.frame(13, 16'h1ABC);
		look(4);
		chk(16'(nibs.size()), 16'h0003);
		chk({4'h0, nibs[2], nibs[1], nibs[0]}, 16'h0ABC);
		$display("dribble done");
	endtask : t_drib
	task automatic t_hb;
		int n;
		for (int e = 0; e < 2; e++) begin
			wr_reg(REG_CFG, (e != 0) ? 16'h0201 : CFG_RESET);
			tx_en_in <= 1'b1;
			repeat (20) @(posedge clock_in);
			tx_en_in <= 1'b0;
			n = 0;
			repeat (SQE_CYC + 50) begin
				@(posedge clock_in);
				n += int'(col_out === 1'b1);
			end
			chk(16'(n), 16'(e * SQE_CYC));
		end
		$display("heartbeat done");
	endtask : t_hb
	task automatic t_jab;
		for (int k = 0; k < 2; k++) begin
			wr_reg(REG_CFG, (k != 0) ? 16'h0401 : CFG_RESET);
			tx_en_in <= 1'b1;
			look(P_JAB + 5);
			chk(16'({tx_enable_out, loopback_enable_out}), 16'h0000);
			@(posedge clock_in);
			tx_en_in <= 1'b0;
			look(P_UNJ + 5);
			chk(16'(loopback_enable_out), 16'(1 - k));
		end
		wr_reg(REG_CFG, CFG_RESET);
		look(4);
		chk(16'(loopback_enable_out), 16'h0001);
		$display("jabber done");
	endtask : t_jab
	task automatic t_page;
		an_evt(1'b1, 1'b0, 1'b1);
		an_evt(1'b0, 1'b1, 1'b1);
		look(20);
		rd_chk(REG_PAGE, 16'h0022, 16'h0022);
		rd_chk(REG_PAGE, 16'h0022, 16'h0000);
		an_evt(1'b1, 1'b0, 1'b0);
		rd_chk(REG_PAGE, 16'h0022, 16'h0002);
		wr_reg(REG_CFG, 16'h0003);
		an_evt(1'b1, 1'b0, 1'b0);
		an_evt(1'b0, 1'b1, 1'b0);
		look(3);
		rd_chk(REG_PAGE, 16'h0022, 16'h0000);
		@(posedge clock_in);
		an_in.speed_100 <= 1'b1;
		an_in.full_duplex <= 1'b1;
		an_in.an_complete <= 1'b1;
		look(3);
		rd_chk(REG_STAT2, 16'h4280, 16'h4280);
		$display("status done");
	endtask : t_page
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		num_errors = 0;
		cmp_count = 0;
		fail_seen = 1'b0;
		restart_seen = 1'b0;
		lp_seen = 1'b0;
		rst_in = 1'b1;
		reg_req_in = '0;
		an_in = '0;
		tx_en_in = 1'b0;
		repeat (8) @(posedge clock_in);
		rst_in <= 1'b0;
		t_ltd();
		t_link();
		t_pol();
		t_drib();
		t_hb();
		t_jab();
		t_page();
		report_and_stop();
	end
endmodule : tb_top
bind tblm_top tblm_sva #(.NLP_CYC(NLP_CYC), .JABBER_CYC(JABBER_CYC),
	.UNJAB_CYC(UNJAB_CYC)) u_sva (.clock_in(clock_in), .rst_in(rst_in),
	.reg_req_in(reg_req_in), .an_in(an_in), .tx_en_in(tx_en_in),
	.tx_link_pulse_out(tx_link_pulse_out),
	.tx_enable_out(tx_enable_out),
	.loopback_enable_out(loopback_enable_out), .col_out(col_out),
	.an_restart_out(an_restart_out), .link_fail_out(link_fail_out));
